/* File: spisb_pkg.sv */
package spisb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_DATA  = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL1_RXFIE_BIT = 7;  // rx_fault_irq_enable
  localparam int CTRL1_TXIE_BIT  = 5;  // tx_irq_enable
  localparam int CTRL1_MASTER_SELECT_BIT  = 4;  // master_select
  localparam int CTRL1_SELECT_OUTPUT_ENABLE_BIT  = 1;  // select_output_enable
  localparam int CTRL2_FDEN_BIT  = 4;  // fault_detect_enable
  localparam int FLAG_RXF_BIT    = 7;  // rx_full_flag
  localparam int FLAG_TXE_BIT    = 5;  // tx_empty_flag
  localparam int FLAG_MODE_FAULT_FLAG_BIT   = 4;  // mode_fault_flag

  // ---------------------------------------------------------------
  // Reset values and bus encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Byte handed between the buffers and the external shifter
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } spisb_byte_t;

  // Configuration seen by the external shifter
  typedef struct packed {
    logic master_select;
    logic select_output_enable;
    logic fault_detect_enable;
  } spisb_cfg_t;

endpackage

/* File: spisb_top.sv */
// Overview of operation
// RULE_01: Flags word: rx full bit 7, tx empty bit 5, fault bit 4, rest zero.
// RULE_02: Writing the flags register changes nothing.
// RULE_03: Finished serial transfer sets the receive-full flag.
// RULE_04: Receive-full clears by flags read while set, then data read.
// RULE_05: Tx-empty sets when buffer has room, e.g. byte moves to shifter.
// RULE_06: Tx-empty clears by flags read while set, then data write.
// RULE_07: Data write without prior flags read seeing tx-empty is ignored.
// RULE_08: Tx-empty with tx interrupt enable raises the interrupt request.
// RULE_09: Idle block moves written byte to shifter, tx-empty back in two cycles.
// RULE_10: At shift end a waiting byte moves to shifter and starts next transfer.
// RULE_11: No waiting byte at shift end: tx-empty stays set, nothing moves.
// RULE_12: Master mode with select input low sets the mode-fault flag.
// RULE_13: Mode fault only with master, fault detect on, select output off.
// RULE_14: Mode fault clears by flags read while set, then control-1 write.
// RULE_15: Data read gives receive buffer, data write loads transmit buffer.
// RULE_16: In master mode, loading the transmit buffer starts a transfer.
// RULE_17: Software should write data only while tx-empty shows room.
// RULE_18: Unread byte at next completion is kept; new byte is dropped.
// RULE_19: Receive/fault interrupt enable gates receive-full and fault flags.
// RULE_20: No flag reports a receive overrun.
// RULE_21: After reset tx-empty set, other flags clear, buffers empty.
module spisb_top
  import spisb_pkg::*;
(
  input  wire logic        hclk,          // Bus clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select from decoder
  input  wire logic [7:0]  haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  input  wire logic        ss_in_n,       // Slave select pin, active low
  input  spisb_byte_t      rx_done,       // Shifter finished, received byte
  output spisb_byte_t      tx_load,       // Byte moved into shifter, pulse
  output spisb_cfg_t       cfg,           // Mode bits for the shifter
  output logic             irq            // Interrupt request, active high
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl2_r;
  logic [7:0]  tx_buf_r;
  logic        tx_buf_full_r;
  logic [7:0]  rx_buf_r;
  logic        rx_full_r;
  logic        tx_empty_r;
  logic        mode_fault_flag_r;
  logic        shifter_busy_r;
  logic        rx_armed_r;
  logic        tx_armed_r;
  logic        mode_fault_flag_armed_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  logic        irq_r;
  spisb_byte_t tx_load_r;
  spisb_cfg_t  cfg_r;
  logic        ss_meta_r;
  logic        ss_sync_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       addr_phase;
  logic       rd_flags;
  logic       rd_data;
  logic       wr_data;
  logic       wr_ctrl1;
  logic       wr_ctrl2;
  logic       tx_accept;
  logic       move_to_shifter;
  logic       shifter_idle;
  logic       fault_now;
  logic [7:0] flags_word;
  logic       tx_arm_set;
  logic       rx_arm_set;
  logic       mode_fault_flag_arm_set;
  logic       rx_clear;
  logic       rx_take;
  logic       master_select;
  logic       select_output_enable;
  logic       fault_detect_enable;
  logic       tx_irq_enable;
  logic       rx_fault_irq_enable;
  logic       tx_irq_src;
  logic       rx_irq_src;

  // Word-aligned register match on address bits 7:2, low two bits ignored
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a[7:2] == reg_addr[7:2]);
  endfunction

  // Address phase of a valid transfer to this slave
  assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == HTRANS_SEQ);
  assign rd_flags   = addr_phase & ~hwrite & hit(haddr, ADDR_FLAGS);
  assign rd_data    = addr_phase & ~hwrite & hit(haddr, ADDR_DATA);
  // Data-phase writes use the stored address; flags writes decode to nothing
  assign wr_data    = wr_pend_r & hit(wr_addr_r, ADDR_DATA);
  assign wr_ctrl1   = wr_pend_r & hit(wr_addr_r, ADDR_CTRL1);
  assign wr_ctrl2   = wr_pend_r & hit(wr_addr_r, ADDR_CTRL2);            // [RULE_02]

  // Flags reads that arm the clear of each flag
  assign tx_arm_set   = rd_flags & tx_empty_r;
  assign rx_arm_set   = rd_flags & rx_full_r;
  assign mode_fault_flag_arm_set = rd_flags & mode_fault_flag_r;

  // Flags word with unused bits tied low
  always_comb begin
    flags_word                = 8'h00;                                   // [RULE_01]
    flags_word[FLAG_RXF_BIT]  = rx_full_r;                               // [RULE_01]
    flags_word[FLAG_TXE_BIT]  = tx_empty_r;                              // [RULE_01]
    flags_word[FLAG_MODE_FAULT_FLAG_BIT] = mode_fault_flag_r;                                  // [RULE_01]
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, OKAY only
  // ---------------------------------------------------------------
  // Capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= haddr;
    end
  end

  // Read data registered at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      if (hit(haddr, ADDR_CTRL1)) begin
        hrdata_r <= {24'h000000, ctrl1_r};
      end else if (hit(haddr, ADDR_CTRL2)) begin
        hrdata_r <= {24'h000000, ctrl2_r};
      end else if (hit(haddr, ADDR_FLAGS)) begin
        hrdata_r <= {24'h000000, flags_word};
      end else if (hit(haddr, ADDR_DATA)) begin
        hrdata_r <= {24'h000000, rx_buf_r};                              // [RULE_15]
      end else begin
        hrdata_r <= 32'h00000000;
      end
    end
  end

  // Ready and response registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_r;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Writable mode and enable bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_r <= CTRL1_RESET;
      ctrl2_r <= CTRL2_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_r <= hwdata[7:0];
      end
      if (wr_ctrl2) begin
        ctrl2_r <= hwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control field decode
  // ---------------------------------------------------------------
  // Named mode and enable bits read by several processes
  assign master_select        = ctrl1_r[CTRL1_MASTER_SELECT_BIT];
  assign select_output_enable = ctrl1_r[CTRL1_SELECT_OUTPUT_ENABLE_BIT];
  assign fault_detect_enable  = ctrl2_r[CTRL2_FDEN_BIT];
  assign tx_irq_enable        = ctrl1_r[CTRL1_TXIE_BIT];
  assign rx_fault_irq_enable  = ctrl1_r[CTRL1_RXFIE_BIT];

  // Mode bits registered toward the shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= '0;
    end else begin
      cfg_r.master_select        <= master_select;
      cfg_r.select_output_enable <= select_output_enable;
      cfg_r.fault_detect_enable  <= fault_detect_enable;
    end
  end

  assign cfg = cfg_r;

  // ---------------------------------------------------------------
  // Slave select pin synchroniser
  // ---------------------------------------------------------------
  // Two flops; only the second is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_meta_r <= 1'b1;
      ss_sync_r <= 1'b1;
    end else begin
      ss_meta_r <= ss_in_n;
      ss_sync_r <= ss_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  // Write accepted only after a flags read that saw room
  assign tx_accept    = wr_data & tx_armed_r;                            // [RULE_07]
  assign shifter_idle = ~shifter_busy_r | rx_done.valid;
  // Buffered byte moves when the shifter is idle or just finished
  assign move_to_shifter = tx_buf_full_r & shifter_idle;                 // [RULE_10]

  // Arm a data write when a flags read sees tx_empty set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_armed_r <= 1'b0;
    end else if (tx_arm_set) begin
      tx_armed_r <= 1'b1;                                                // [RULE_06]
    end else if (tx_accept) begin
      tx_armed_r <= 1'b0;
    end
  end

  // Transmit buffer: loaded by write, emptied into the shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_r      <= BYTE_RESET;                                       // [RULE_21]
      tx_buf_full_r <= 1'b0;                                             // [RULE_21]
    end else if (tx_accept) begin
      tx_buf_r      <= hwdata[7:0];                                      // [RULE_15]
      tx_buf_full_r <= 1'b1;
    end else if (move_to_shifter) begin
      tx_buf_full_r <= 1'b0;
    end
  end

  // Tx-empty: set on move into shifter, clear on accepted write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_r <= 1'b1;                                                // [RULE_21]
    end else if (move_to_shifter) begin
      tx_empty_r <= 1'b1;                                                // [RULE_05] [RULE_09]
    end else if (tx_accept) begin
      tx_empty_r <= 1'b0;                                                // [RULE_06]
    end else begin
      tx_empty_r <= ~tx_buf_full_r;                                      // [RULE_11]
    end
  end

  // Shifter handoff pulse; in master mode it starts the transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_load_r <= '0;
    end else begin
      tx_load_r.valid <= move_to_shifter;                                // [RULE_16] [RULE_09]
      tx_load_r.data  <= move_to_shifter ? tx_buf_r : tx_load_r.data;
    end
  end

  assign tx_load = tx_load_r;

  // Shifter occupancy, cleared by completion unless reloaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shifter_busy_r <= 1'b0;
    end else if (move_to_shifter) begin
      shifter_busy_r <= 1'b1;                                            // [RULE_10]
    end else if (rx_done.valid) begin
      shifter_busy_r <= 1'b0;                                            // [RULE_11]
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  // Armed data read empties the buffer; a byte finishing then is still taken
  assign rx_clear = rd_data & rx_armed_r;                                // [RULE_04]
  assign rx_take  = rx_done.valid & (~rx_full_r | rx_clear);             // [RULE_18]

  // Arm the clear when a flags read sees rx_full set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_armed_r <= 1'b0;
    end else if (rx_arm_set) begin
      rx_armed_r <= 1'b1;                                                // [RULE_04]
    end else if (rd_data) begin
      rx_armed_r <= 1'b0;
    end
  end

  // Receive buffer keeps an unread byte; a new one is dropped silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_r <= BYTE_RESET;                                            // [RULE_21]
    end else if (rx_take) begin
      rx_buf_r <= rx_done.data;                                          // [RULE_18] [RULE_20]
    end
  end

  // Rx-full: completion sets, armed data read clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_full_r <= 1'b0;                                                 // [RULE_21]
    end else if (rx_done.valid) begin
      rx_full_r <= 1'b1;                                                 // [RULE_03]
    end else if (rx_clear) begin
      rx_full_r <= 1'b0;                                                 // [RULE_04]
    end
  end

  // ---------------------------------------------------------------
  // Mode fault
  // ---------------------------------------------------------------
  // Select input low in master mode with fault detect and no select output
  assign fault_now = master_select & fault_detect_enable
                   & ~select_output_enable & ~ss_sync_r;                 // [RULE_12] [RULE_13]

  // Arm the clear when a flags read sees the fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_fault_flag_armed_r <= 1'b0;
    end else if (mode_fault_flag_arm_set) begin
      mode_fault_flag_armed_r <= 1'b1;                                              // [RULE_14]
    end else if (wr_ctrl1) begin
      mode_fault_flag_armed_r <= 1'b0;
    end
  end

  // Fault flag: set wins over the control-1 clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_fault_flag_r <= 1'b0;                                                    // [RULE_21]
    end else if (fault_now) begin
      mode_fault_flag_r <= 1'b1;                                                    // [RULE_12]
    end else if (wr_ctrl1 && mode_fault_flag_armed_r) begin
      mode_fault_flag_r <= 1'b0;                                                    // [RULE_14]
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  // Each source gated by its own enable
  assign tx_irq_src = tx_empty_r & tx_irq_enable;                        // [RULE_08]
  assign rx_irq_src = (rx_full_r | mode_fault_flag_r) & rx_fault_irq_enable;        // [RULE_19]

  // Combined request from enabled flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= tx_irq_src | rx_irq_src;                                  // [RULE_08] [RULE_19]
    end
  end

  assign irq = irq_r;

endmodule

/* File: spisb_sva.sv */
// ------------------------------
// Port checker for the status and data block
// ------------------------------
module spisb_sva
  import spisb_pkg::*;
(
  input  wire logic        hclk,       // Clock
  input  wire logic        hresetn,    // Reset, active low
  input  wire logic        hsel,       // Select
  input  wire logic [7:0]  haddr,      // Address
  input  wire logic [1:0]  htrans,     // Type
  input  wire logic        hwrite,     // Write
  input  wire logic [2:0]  hsize,      // Size
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Ready in
  input  wire logic [31:0] hrdata,     // Read data
  input  wire logic        hreadyout,  // Ready out
  input  wire logic        hresp,      // Response
  input  wire logic        ss_in_n,    // Select pin
  input  spisb_byte_t      rx_done,    // Frame done
  input  spisb_byte_t      tx_load,    // Shifter load
  input  spisb_cfg_t       cfg,        // Mode bits
  input  wire logic        irq         // Interrupt
);
  logic ap, rd_ap, flg_rd, dat_wr, c1_wr, c2_wr;

  // Address phase decode
  assign ap     = hsel && hready && htrans[1];
  assign rd_ap  = ap && !hwrite;
  assign flg_rd = rd_ap && (haddr[7:2] == ADDR_FLAGS[7:2]);
  assign dat_wr = ap && hwrite && (haddr[7:2] == ADDR_DATA[7:2]);
  assign c1_wr  = ap && hwrite && (haddr[7:2] == ADDR_CTRL1[7:2]);
  assign c2_wr  = ap && hwrite && (haddr[7:2] == ADDR_CTRL2[7:2]);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_c1_wr;
    c1_wr ##1 1'b1;
  endsequence
  sequence s_c2_wr;
    c2_wr ##1 1'b1;
  endsequence
  sequence s_irq_off;
    c1_wr ##1 (!hwdata[CTRL1_RXFIE_BIT] && !hwdata[CTRL1_TXIE_BIT]);
  endsequence

  property p_bus_ok;
    hreadyout && (hresp == HRESP_OKAY);
  endproperty
  property p_reset_vals;
    $rose(hresetn) |-> (hrdata == 32'h0) && !tx_load.valid && !irq && (cfg == 3'h0);
  endproperty
  property p_flags_fmt;
    flg_rd |=> (hrdata[31:8] == 24'h0) && !hrdata[6] && (hrdata[3:0] == 4'h0);
  endproperty
  property p_rdata_stand;
    !$stable(hrdata) |-> $past(rd_ap);
  endproperty
  property p_load_cause;
    tx_load.valid |-> $past(rx_done.valid) || $past(rx_done.valid, 2) || $past(dat_wr, 3);
  endproperty
  property p_load_hold;
    !tx_load.valid |-> $stable(tx_load.data);
  endproperty
  property p_cfg1;
    s_c1_wr |-> ##2 (cfg.master_select == $past(hwdata[CTRL1_MASTER_SELECT_BIT], 2))
      && (cfg.select_output_enable == $past(hwdata[CTRL1_SELECT_OUTPUT_ENABLE_BIT], 2));
  endproperty
  property p_cfg2;
    s_c2_wr |-> ##2 (cfg.fault_detect_enable == $past(hwdata[CTRL2_FDEN_BIT], 2));
  endproperty
  property p_irq_off;
    s_irq_off |-> ##2 !irq;
  endproperty

  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
  a_flags_fmt: assert property (p_flags_fmt) else $error("flags unused bit set");
  a_rdata_stand: assert property (p_rdata_stand) else $error("read data moved");
  a_load_cause: assert property (p_load_cause) else $error("load without cause");
  a_load_hold: assert property (p_load_hold) else $error("load byte moved");
  a_cfg1: assert property (p_cfg1) else $error("mode bits lag control one");
  a_cfg2: assert property (p_cfg2) else $error("fault enable lags control two");
  a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
endmodule

bind spisb_top spisb_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ss_in_n(ss_in_n),
  .rx_done(rx_done), .tx_load(tx_load), .cfg(cfg), .irq(irq));

/* File: spisb_shifter_model.sv */
module spisb_shifter_model
  import spisb_pkg::*;
(
  input  wire logic       hclk,     // Bus clock
  input  wire logic       hresetn,  // Reset, active low
  input  spisb_byte_t     tx_load,  // Byte handed over
  input  wire logic [7:0] delay,    // Frame length in cycles
  output spisb_byte_t     rx_done   // Frame finished
);
  logic       busy_r;
  logic [7:0] cnt_r;
  logic [7:0] shift_r;

  // One frame per load; reply is the sent byte with nibbles swapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r  <= 1'b0;
      cnt_r   <= 8'h00;
      shift_r <= 8'h00;
      rx_done <= '0;
    end else begin
      rx_done.valid <= 1'b0;
      rx_done.data  <= ~rx_done.data;  // Data inverted every idle cycle, not held between frames
      if (tx_load.valid) begin
        busy_r  <= 1'b1;
        cnt_r   <= delay;
        shift_r <= tx_load.data;
      end else if (busy_r && (cnt_r != 8'h00)) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (busy_r) begin
        busy_r  <= 1'b0;
        rx_done <= '{valid: 1'b1, data: {shift_r[3:0], shift_r[7:4]}};
      end
    end
  end
endmodule

/* File: spisb_tb.sv */
module spisb_tb
  import spisb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, ss_in_n, hreadyout, hresp, irq;
  logic [7:0]  haddr, sh_delay, load_byte;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd_d;
  spisb_byte_t rx_done, tx_load;
  spisb_cfg_t  cfg;
  int          err_count, total_checks, load_cnt, rx_cnt;

  spisb_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ss_in_n(ss_in_n),
    .rx_done(rx_done), .tx_load(tx_load), .cfg(cfg), .irq(irq));
  spisb_shifter_model i_far (.hclk(hclk), .hresetn(hresetn), .tx_load(tx_load),
    .delay(sh_delay), .rx_done(rx_done));

  // 25 MHz clock
  always #20 hclk = ~hclk;

  // Count loads into the shifter and finished frames
  always @(posedge hclk) begin
    if (tx_load.valid === 1'b1) begin
      load_cnt  <= load_cnt + 1;
      load_byte <= tx_load.data;
    end
    if (rx_done.valid === 1'b1)
      rx_cnt <= rx_cnt + 1;
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d, checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  // One single word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d}, rd_d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, rd_d);
    chk(rd_d, e);
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (rx_cnt < n && k < 200) begin
      @(posedge hclk);
      k++;
    end
    if (rx_cnt < n) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic ss_pulse();
    ss_in_n <= 1'b0;
    repeat (4) @(posedge hclk);
    ss_in_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset_map();
    rd_chk(ADDR_DATA, 32'h0);
    wr(ADDR_CTRL1, 8'h10);
    wr(ADDR_DATA, 8'h77);
    repeat (4) @(posedge hclk);
    chk(load_cnt, 32'h0);
    rd_chk(ADDR_FLAGS, 32'h20);
    wr(ADDR_FLAGS, 8'hFF);
    rd_chk(ADDR_FLAGS, 32'h20);
    rd_chk(8'h3C, 32'h0);
  endtask
  task automatic t_idle_xfer();
    rd_chk(ADDR_FLAGS, 32'h20);
    wr(ADDR_DATA, 8'h12);
    @(posedge hclk);
    rd_chk(ADDR_FLAGS, 32'h20);
    chk(load_byte, 32'h12);
    wait_rx(1);
    rd_chk(ADDR_DATA, 32'h21);
    rd_chk(ADDR_FLAGS, 32'hA0);
    rd_chk(ADDR_DATA, 32'h21);
    rd_chk(ADDR_FLAGS, 32'h20);
  endtask
  task automatic t_queue_overrun();
    sh_delay <= 8'h14;
    rd_chk(ADDR_FLAGS, 32'h20);
    wr(ADDR_DATA, 8'h34);
    @(posedge hclk);
    rd_chk(ADDR_FLAGS, 32'h20);
    wr(ADDR_DATA, 8'h56);
    rd_chk(ADDR_FLAGS, 32'h00);
    wait_rx(3);
    repeat (2) @(posedge hclk);
    chk(load_cnt, 32'h3);
    chk(load_byte, 32'h56);
    rd_chk(ADDR_FLAGS, 32'hA0);
    rd_chk(ADDR_DATA, 32'h43);
    repeat (30) @(posedge hclk);
    chk(load_cnt, 32'h3);
    rd_chk(ADDR_FLAGS, 32'h20);
  endtask
  task automatic t_fault();
    logic f;
    for (int i = 0; i < 8; i++) begin
      f = i[0] && i[1] && !i[2];
      wr(ADDR_CTRL2, {3'h0, i[1], 4'h0});
      wr(ADDR_CTRL1, {3'h0, i[0], 2'h0, i[2], 1'b0});
      ss_pulse();
      wr(ADDR_CTRL1, 8'h00);
      rd_chk(ADDR_FLAGS, {27'h0, f, 4'h0} | 32'h20);
      wr(ADDR_CTRL1, 8'h00);
      rd_chk(ADDR_FLAGS, 32'h20);
    end
  endtask
  task automatic t_irq();
    wr(ADDR_CTRL1, 8'h20);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h1);
    wr(ADDR_CTRL1, 8'h80);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h0);
    wr(ADDR_CTRL2, 8'h10);
    wr(ADDR_CTRL1, 8'h90);
    ss_pulse();
    chk(irq, 32'h1);
    rd_chk(ADDR_FLAGS, 32'h30);
    wr(ADDR_CTRL1, 8'h80);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h0);
    sh_delay <= 8'h02;
    rd_chk(ADDR_FLAGS, 32'h20);
    wr(ADDR_DATA, 8'h5A);
    wait_rx(4);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h1);
  endtask

  // Reset, then the scenarios in order
  initial begin
    hclk      = 1'b0;
    hresetn   = 1'b0;
    hsel      = 1'b1;
    haddr     = 8'h00;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    ss_in_n   = 1'b1;
    sh_delay  = 8'h04;
    load_byte = 8'h00;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_map();
    t_idle_xfer();
    t_queue_overrun();
    t_fault();
    t_irq();
    close_out();
  end
endmodule
